// file: hw/mrw_map.vh
// mrw_map.vh: constants for the reset and watchdog controller
// assumes the design runs on the 50 MHz peripheral clock and includes this file by bare name
`ifndef MRW_MAP_VH
`define MRW_MAP_VH

// register byte offsets
`define MRW_CTRL_OFS        12'h000
`define MRW_STAT_OFS        12'h004
`define MRW_WDCNT_OFS       12'h008
`define MRW_CFG_OFS         12'h00C

// control register fields (write side effects only, reads as zero)
`define MRW_CTRL_WDCLR_BIT  0
`define MRW_CTRL_HALT_BIT   1
`define MRW_CTRL_SWRST_BIT  2

// status register fields
`define MRW_STAT_INRST_BIT  0
`define MRW_STAT_ARMED_BIT  1
`define MRW_STAT_CAUSE_LSB  4

// config register fields
`define MRW_CFG_KEYEN_LSB   0
`define MRW_CFG_KEYSRC_BIT  4

// reset cycle lengths in divider clocks
`define MRW_RST_LONG        16384
`define MRW_RST_SHORT       2048

// watchdog overflow intervals in stage ten periods
`define MRW_WD_SEL8         2'h0
`define MRW_WD_SEL64        2'h1
`define MRW_WD_SEL512       2'h2

// stage ten of the divider toggles once per 512 input clocks
`define MRW_STAGE_TEN_DIV   512
`define MRW_STAGE_EIGHT_DIV 128

// cause encodings
`define MRW_CAUSE_POR       4'h1
`define MRW_CAUSE_PIN       4'h2
`define MRW_CAUSE_KEY       4'h4
`define MRW_CAUSE_WDOG      4'h8

// reset-state encodings for downstream blocks
`define MRW_DUTY_QUARTER    2'h0
`define MRW_PC_RESET        12'h000

`endif

// file: hw/mrw_reset_watchdog.v
// mrw_reset_watchdog.v: reset controller, key reset and watchdog timer of a small 4-bit core
// assumes pclk at 50 MHz, an APB master, and that pins arrive asynchronous to pclk
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "mrw_map.vh"

// How it works
// R1: a high reset pin raises a reset request; pin idles low.
// R2: level mode holds reset while pin high; cycle starts when it falls.
// R3: pulse mode starts the cycle on a high and releases automatically afterwards.
// R4: reset cycle lasts 16384 or 2048 divider clocks, chosen at build.
// R5: program counter is loaded with zero during reset.
// R6: flags, release enables, switch enables and interrupt enables clear to zero.
// R7: battery indicator resets to one or zero by supply variant.
// R8: ports go to input mode; third and fourth port pull-downs on.
// R9: debounce clock stage ten; pump and clear clocks quarter duty; generator off.
// R10: buzzer low, converter off with sense outputs zero, timers off.
// R11: slow crystal clock selected; watchdog in reset mode, flag zero. (code keeps the flag on key and watchdog reset)
// R12: segment outputs all-on or all-off during reset, chosen at build.
// R13: key reset fires when every enabled key input reads zero.
// R14: key-matrix reset waits for the next scanning clock pulse.
// R15: watchdog is a nine-bit up-counter clocked by stage ten.
// R16: watchdog overflow resets most logic but keeps watchdog, flag and divider.
// R17: power-on or pin reset stops the watchdog and clears its flag.
// R18: set-flag instruction with 10h arms watchdog, sets flag, clears count.
// R19: watchdog holds its count in halt or stop and resumes after.
// R20: firmware must clear the watchdog often enough to avoid overflow.
// R21: firmware should clear the watchdog before entering halt or stop.
// R22: overflow interval is 8, 64 or 512 stage-ten periods, build selected.
// R23: all reset requests merge into one synchronised request before the cycle.
module mrw_reset_watchdog #(
   parameter            LONG_RESET  = 1,
   parameter            PULSE_MODE  = 0,
   parameter            BATTERY_VAR = 1,
   parameter            SEG_ALL_ON  = 1,
   parameter [3:0]      KEY_USE     = 4'hF,
   parameter [1:0]      WD_SEL      = `MRW_WD_SEL512,
   parameter integer    RST_LONG    = `MRW_RST_LONG,
   parameter integer    RST_SHORT   = `MRW_RST_SHORT,
   parameter integer    STAGE_DIV   = `MRW_STAGE_TEN_DIV
) (
   // clock and bus reset
   input  wire          pclk,
   input  wire          presetn,
   // apb slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   // external pins and events
   input  wire          por_request,
   input  wire          reset_pin,
   input  wire [3:0]    key_scan_inputs,
   input  wire          key_scan_clock,
   input  wire          cpu_sleeping,
   // reset state handed to the core
   output reg           core_in_reset,
   output reg  [11:0]   program_counter_load,
   output reg           clear_flags,
   output reg           battery_backup_indicator,
   output reg  [3:0]    port_input_mode,
   output reg  [1:0]    pull_down_cd,
   output reg           debounce_from_stage_ten,
   output reg  [1:0]    pump_duty,
   output reg  [1:0]    clear_duty,
   output reg           freq_gen_active,
   output reg           buzzer_level,
   output reg           converter_active,
   output reg  [2:0]    sense_resistor_outputs,
   output reg  [1:0]    timers_active,
   output reg           use_slow_crystal_clock,
   output reg           segments_forced,
   output reg           segment_force_level,
   output reg           watchdog_armed_flag,
   output reg           divider_stage_ten_output
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_HOLD = 3'b010;
   localparam [2:0] ST_CYC  = 3'b100;
   localparam integer CYC_LEN = LONG_RESET ? RST_LONG : RST_SHORT;
   localparam [8:0] WD_LIMIT = (WD_SEL == `MRW_WD_SEL8)  ? 9'h007 :
                               (WD_SEL == `MRW_WD_SEL64) ? 9'h03F : 9'h1FF;

   //////////////////////////////////////////////////////////////////////////////
   // three-flop synchronisers; a change counts once flops two and three agree
   reg  [2:0]  pin_s;
   reg  [2:0]  por_s;
   reg  [2:0]  ksc_s;
   reg  [3:0]  key_s1;
   reg  [3:0]  key_s2;
   reg  [3:0]  key_s3;
   reg         pin_f;
   reg         por_f;
   reg         ksc_f;
   reg  [3:0]  key_f;
   reg         ksc_prev;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s    <= 3'h0;
         por_s    <= 3'h0;
         ksc_s    <= 3'h0;
         key_s1   <= 4'hF;
         key_s2   <= 4'hF;
         key_s3   <= 4'hF;
         pin_f    <= 1'b0;
         por_f    <= 1'b0;
         ksc_f    <= 1'b0;
         ksc_prev <= 1'b0;
      end else begin
         pin_s    <= {pin_s[1:0], reset_pin};
         por_s    <= {por_s[1:0], por_request};
         ksc_s    <= {ksc_s[1:0], key_scan_clock};
         key_s1   <= key_scan_inputs;
         key_s2   <= key_s1;
         key_s3   <= key_s2;
         if (pin_s[1] == pin_s[2])
            pin_f <= pin_s[2];
         if (por_s[1] == por_s[2])
            por_f <= por_s[2];
         if (ksc_s[1] == ksc_s[2])
            ksc_f <= ksc_s[2];
         ksc_prev <= ksc_f;
      end
   end

   // per-bit key filter
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_key
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               key_f[gi] <= 1'b1;
            else if (key_s2[gi] == key_s3[gi])
               key_f[gi] <= key_s3[gi];
         end
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////////
   // software state: key reset enables, source select, halt indication
   reg  [3:0]  key_en;
   reg         key_from_matrix;
   reg         sw_halt;
   reg  [3:0]  last_cause;
   wire        apb_wr = psel & penable & pwrite & pready;
   wire        wr_ctrl = apb_wr && (paddr == `MRW_CTRL_OFS);
   wire        wr_cfg  = apb_wr && (paddr == `MRW_CFG_OFS);
   wire        wd_clear = wr_ctrl && pwdata[`MRW_CTRL_WDCLR_BIT];
   wire        sw_reset = wr_ctrl && pwdata[`MRW_CTRL_SWRST_BIT];

   //////////////////////////////////////////////////////////////////////////////
   // key reset: all enabled inputs low; matrix source waits for scan clock edge
   wire        key_all_low = (KEY_USE & key_en) != 4'h0 &&
                             ((key_f & KEY_USE & key_en) == 4'h0);        // [R13]
   wire        scan_edge = ksc_f & ~ksc_prev;
   reg         key_req;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         key_req <= 1'b0;
      else if (!key_all_low)
         key_req <= 1'b0;
      else if (!key_from_matrix || scan_edge)
         key_req <= 1'b1;                                                 // [R14]
   end

   //////////////////////////////////////////////////////////////////////////////
   // divider: free-running, never cleared by watchdog reset
   reg  [9:0]  div_cnt;
   reg         stage_ten_tick;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt                  <= 10'h000;
         divider_stage_ten_output <= 1'b0;
         stage_ten_tick           <= 1'b0;
      end else begin
         div_cnt <= div_cnt + 10'h001;                                    // [R16]
         stage_ten_tick <= 1'b0;
         if (div_cnt == STAGE_DIV[9:0] - 10'h001) begin
            div_cnt                  <= 10'h000;
            divider_stage_ten_output <= ~divider_stage_ten_output;
            stage_ten_tick           <= ~divider_stage_ten_output;        // rising edge
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // watchdog: nine-bit up counter on stage ten rising edges
   reg  [8:0]  wd_cnt;
   reg         wd_ovf;
   wire        hard_req = por_f | pin_f | sw_reset;                       // [R17]

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_cnt              <= 9'h000;
         watchdog_armed_flag <= 1'b0;
         wd_ovf              <= 1'b0;
      end else begin
         wd_ovf <= 1'b0;
         if (hard_req) begin
            watchdog_armed_flag <= 1'b0;                                  // [R11] [R17]
            wd_cnt              <= 9'h000;
         end else if (wd_clear) begin
            watchdog_armed_flag <= 1'b1;                                  // [R18]
            wd_cnt              <= 9'h000;
         end else if (watchdog_armed_flag && stage_ten_tick &&
                      !(cpu_sleeping || sw_halt)) begin                   // [R19]
            if (wd_cnt == WD_LIMIT) begin
               wd_cnt <= 9'h000;                                          // [R22]
               wd_ovf <= 1'b1;                                            // flag kept [R16]
            end else
               wd_cnt <= wd_cnt + 9'h001;                                 // [R15]
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // reset sequencer; merged request is already synchronised to pclk
   reg  [2:0]  state;
   reg  [14:0] cyc_cnt;
   wire        any_req = hard_req | key_req | wd_ovf;                     // [R23]
   wire        hold_req = PULSE_MODE ? 1'b0 : pin_f;                      // [R2]
   reg         pin_seen;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= ST_CYC;
         cyc_cnt  <= 15'h0000;
         pin_seen <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (any_req && !(pin_seen && pin_f)) begin                 // [R1]
                  pin_seen <= pin_f;
                  cyc_cnt  <= 15'h0000;
                  state    <= hold_req ? ST_HOLD : ST_CYC;
               end else if (!pin_f)
                  pin_seen <= 1'b0;
            end
            ST_HOLD: begin
               cyc_cnt <= 15'h0000;
               if (!pin_f)
                  state <= ST_CYC;                                        // [R2]
            end
            ST_CYC: begin
               if (hold_req)
                  state <= ST_HOLD;
               else if (cyc_cnt == CYC_LEN[14:0] - 15'h0001) begin        // [R4]
                  state    <= ST_IDLE;                                    // [R3]
                  pin_seen <= pin_f;
               end else
                  cyc_cnt <= cyc_cnt + 15'h0001;
            end
            default: state <= ST_CYC;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // reset-state outputs, driven from flops
   wire        in_rst = (state != ST_IDLE);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_in_reset            <= 1'b1;
         program_counter_load     <= `MRW_PC_RESET;
         clear_flags              <= 1'b1;
         battery_backup_indicator <= (BATTERY_VAR != 0);
         port_input_mode          <= 4'hF;
         pull_down_cd             <= 2'h3;
         debounce_from_stage_ten  <= 1'b1;
         pump_duty                <= `MRW_DUTY_QUARTER;
         clear_duty               <= `MRW_DUTY_QUARTER;
         freq_gen_active          <= 1'b0;
         buzzer_level             <= 1'b0;
         converter_active         <= 1'b0;
         sense_resistor_outputs   <= 3'h0;
         timers_active            <= 2'h0;
         use_slow_crystal_clock   <= 1'b1;
         segments_forced          <= 1'b1;
         segment_force_level      <= (SEG_ALL_ON != 0);
      end else begin
         core_in_reset        <= in_rst;
         program_counter_load <= `MRW_PC_RESET;                           // [R5]
         clear_flags          <= in_rst;                                  // [R6]
         if (in_rst) begin
            battery_backup_indicator <= (BATTERY_VAR != 0);               // [R7]
            port_input_mode          <= 4'hF;                             // [R8]
            pull_down_cd             <= 2'h3;
            debounce_from_stage_ten  <= 1'b1;                             // [R9]
            pump_duty                <= `MRW_DUTY_QUARTER;
            clear_duty               <= `MRW_DUTY_QUARTER;
            freq_gen_active          <= 1'b0;
            buzzer_level             <= 1'b0;                             // [R10]
            converter_active         <= 1'b0;
            sense_resistor_outputs   <= 3'h0;
            timers_active            <= 2'h0;
            use_slow_crystal_clock   <= 1'b1;                             // [R11]
         end
         segments_forced     <= in_rst;                                   // [R12]
         segment_force_level <= (SEG_ALL_ON != 0);
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state so every answer is registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready          <= 1'b0;
         pslverr         <= 1'b0;
         prdata          <= 32'h00000000;
         key_en          <= 4'hF;
         key_from_matrix <= 1'b0;
         sw_halt         <= 1'b0;
         last_cause      <= 4'h0;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= 1'b0;
         if (state == ST_IDLE && any_req)
            last_cause <= {wd_ovf, key_req, pin_f | sw_reset, por_f};
         if (psel && penable && !pready) begin
            prdata <= 32'h00000000;
            case (paddr)
               `MRW_CTRL_OFS:  prdata <= 32'h00000000;
               `MRW_STAT_OFS:  prdata <= {24'h000000, last_cause, 2'h0,
                                          watchdog_armed_flag, in_rst};
               `MRW_WDCNT_OFS: prdata <= {23'h000000, wd_cnt};
               `MRW_CFG_OFS:   prdata <= {27'h0000000, key_from_matrix, key_en};
               default:        pslverr <= 1'b1;                           // unmapped
            endcase
         end
         if (wr_ctrl)
            sw_halt <= pwdata[`MRW_CTRL_HALT_BIT];
         if (wr_cfg) begin
            key_en          <= pwdata[`MRW_CFG_KEYEN_LSB +: 4];
            key_from_matrix <= pwdata[`MRW_CFG_KEYSRC_BIT];
         end
      end
   end

endmodule

// file: verif/mrw_pin_model.sv
// mrw_pin_model.sv: far side of the controller: reset pin, key inputs and scan clock
// assumes the bench changes the commands just after a rising pclk edge
`timescale 1ns/1ps
module mrw_pin_model (
   // clock and commands from the bench
   input  wire logic       pclk,
   input  wire logic       pin_cmd,
   input  wire logic [3:0] key_cmd,
   input  wire logic       scan_cmd,
   // pins toward the controller
   output logic            reset_pin       = 1'h0,
   output logic [3:0]      key_scan_inputs = 4'hF,
   output logic            key_scan_clock  = 1'h0
);
   ////////////////////////////////////////
   // pin idles at pull-down level; scan clock follows its command, still between requests
   always @(posedge pclk) begin
      reset_pin       <= pin_cmd;
      key_scan_inputs <= key_cmd;
      key_scan_clock  <= scan_cmd;  // held level so the three-flop filter keeps the edge
   end
endmodule

// file: verif/mrw_reset_watchdog_checker.sv
// mrw_reset_watchdog_checker.sv: port assertions for the reset and watchdog controller
// assumes it is bound into every controller instance and sees only its ports
`timescale 1ns/1ps
`include "mrw_map.vh"
module mrw_reset_watchdog_checker #(
   parameter         LONG_RESET  = 1,
   parameter         PULSE_MODE  = 0,
   parameter         BATTERY_VAR = 1,
   parameter         SEG_ALL_ON  = 1,
   parameter integer RST_LONG    = `MRW_RST_LONG,
   parameter integer RST_SHORT   = `MRW_RST_SHORT,
   parameter integer STAGE_DIV   = `MRW_STAGE_TEN_DIV
) (
   // clock, reset and bus
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // pin and reset state
   input wire logic        reset_pin,
   input wire logic        core_in_reset,
   input wire logic [11:0] program_counter_load,
   input wire logic        clear_flags,
   input wire logic        battery_backup_indicator,
   input wire logic [3:0]  port_input_mode,
   input wire logic [1:0]  pull_down_cd,
   input wire logic        use_slow_crystal_clock,
   input wire logic        segments_forced,
   input wire logic        segment_force_level,
   input wire logic        watchdog_armed_flag,
   input wire logic        divider_stage_ten_output
);
   localparam int CYC = LONG_RESET ? RST_LONG : RST_SHORT;
   int   low_run;
   int   div_cnt;
   logic d_q;
   logic seen;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   // helper counters: reset length with pin low, stage-ten gap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_run <= 0;
         div_cnt <= 0;
         d_q     <= 1'h0;
         seen    <= 1'h0;
      end else begin
         low_run <= (reset_pin || !core_in_reset) ? 0 : low_run + 1;
         d_q     <= divider_stage_ten_output;
         div_cnt <= (divider_stage_ten_output != d_q) ? 0 : div_cnt + 1;
         seen    <= seen | (divider_stage_ten_output != d_q);
      end
   end
   ////////////////////////////////////////
   // outputs are registered, so they are judged from the second reset cycle on
   a_pc_zero: assert property (core_in_reset && $past(core_in_reset) |->
      program_counter_load == `MRW_PC_RESET) else $error("pc load not zero in reset");
   a_flags_ports: assert property (core_in_reset && $past(core_in_reset) |->
      clear_flags && port_input_mode == 4'hF && pull_down_cd == 2'h3)
      else $error("flag or port reset state wrong");
   a_battery_level: assert property (core_in_reset && $past(core_in_reset) |->
      battery_backup_indicator == (BATTERY_VAR != 0)) else $error("battery indicator wrong");
   a_clock_select: assert property (core_in_reset && $past(core_in_reset) |->
      use_slow_crystal_clock) else $error("slow clock not selected in reset");
   a_segment_force: assert property (core_in_reset && $past(core_in_reset) |->
      segments_forced && segment_force_level == (SEG_ALL_ON != 0))
      else $error("segments not forced in reset");
   a_pin_holds: assert property ((PULSE_MODE == 0 && reset_pin)[*8] |-> core_in_reset)
      else $error("level pin did not hold reset");
   a_cycle_length: assert property ($fell(core_in_reset) && PULSE_MODE == 0 |->
      low_run >= CYC - 1 && low_run <= CYC + 8) else $error("reset cycle length wrong");
   a_pin_clears: assert property (reset_pin[*8] |-> !watchdog_armed_flag)
      else $error("pin reset left watchdog flag set");
   a_arm_flag: assert property (psel && penable && pready && pwrite &&
      paddr == `MRW_CTRL_OFS && pwdata[`MRW_CTRL_WDCLR_BIT] |=> watchdog_armed_flag)
      else $error("watchdog clear did not set flag");
   a_stage_rate: assert property (seen && divider_stage_ten_output != d_q |->
      div_cnt == STAGE_DIV - 1) else $error("stage ten rate wrong");
   c_arm: cover property (psel && penable && pready && pwrite && paddr == `MRW_CTRL_OFS);
   c_pin_release: cover property ($fell(reset_pin) && core_in_reset);
   c_cycle_end: cover property ($fell(core_in_reset));
endmodule

bind mrw_reset_watchdog mrw_reset_watchdog_checker #(.LONG_RESET(LONG_RESET),
   .PULSE_MODE(PULSE_MODE), .BATTERY_VAR(BATTERY_VAR), .SEG_ALL_ON(SEG_ALL_ON),
   .RST_LONG(RST_LONG), .RST_SHORT(RST_SHORT), .STAGE_DIV(STAGE_DIV)) u_chk (.*);

// file: verif/mrw_reset_watchdog_tb.sv
// mrw_reset_watchdog_tb.sv: self-checking bench, level-mode controller beside a pulse-mode one
// assumes shortened counts: 32-cycle reset cycle, stage ten every 4 pclk, 8-period watchdog
`timescale 1ns/1ps
`include "mrw_map.vh"
module mrw_reset_watchdog_tb;
   localparam int CYC = 32;
   localparam int SD = 4;
   localparam int WD_T = 8 * 2 * SD;
   logic pclk = 1'h0;
   logic presetn, psel, penable, pwrite, pready, pslverr, por_request, cpu_sleeping;
   logic [11:0] paddr, program_counter_load;
   logic [31:0] pwdata, prdata, rdat, c;
   logic reset_pin, key_scan_clock, pin_cmd, scan_cmd, rerr, pulse_in_reset;
   logic [3:0] key_cmd, key_scan_inputs, port_input_mode;
   logic core_in_reset, clear_flags, battery_backup_indicator, debounce_from_stage_ten;
   logic freq_gen_active, buzzer_level, converter_active, use_slow_crystal_clock;
   logic segments_forced, segment_force_level, watchdog_armed_flag, divider_stage_ten_output;
   logic [1:0] pull_down_cd, pump_duty, clear_duty, timers_active;
   logic [2:0] sense_resistor_outputs;
   int miscompares = 0;
   int checked = 0;
   int wn;
   logic [11:0] t_addr [5] = '{`MRW_CTRL_OFS, `MRW_STAT_OFS, `MRW_WDCNT_OFS, `MRW_CFG_OFS, 12'h010};
   logic [31:0] t_mask [5] = '{32'hFFFFFFFF, 32'h3, 32'h1FF, 32'h1F, 32'hFFFFFFFF};
   logic [31:0] t_exp  [5] = '{32'h0, 32'h0, 32'h0, 32'hF, 32'h0};
   logic        t_err  [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
   ////////////////////////////////////////
   // 50 MHz clock
   always #10 pclk = ~pclk;
   mrw_pin_model u_pins (.*);
   mrw_reset_watchdog #(.RST_LONG(CYC), .RST_SHORT(16), .STAGE_DIV(SD),
      .WD_SEL(`MRW_WD_SEL8)) dut (.*);
   // pulse-mode twin shares every input; only its reset state is watched
   mrw_reset_watchdog #(.PULSE_MODE(1), .RST_LONG(CYC), .RST_SHORT(16), .STAGE_DIV(SD),
      .WD_SEL(`MRW_WD_SEL8)) dut_pulse (.*, .prdata(), .pready(), .pslverr(),
      .core_in_reset(pulse_in_reset), .program_counter_load(),
      .clear_flags(), .battery_backup_indicator(), .port_input_mode(), .pull_down_cd(),
      .debounce_from_stage_ten(), .pump_duty(), .clear_duty(), .freq_gen_active(),
      .buzzer_level(), .converter_active(), .sense_resistor_outputs(), .timers_active(),
      .use_slow_crystal_clock(), .segments_forced(), .segment_force_level(),
      .watchdog_armed_flag(), .divider_stage_ten_output());
   ////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one apb transfer, idle edge first
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 50);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0; penable <= 1'h0;
   endtask
   // bounded wait on core_in_reset, edges in wn
   task automatic wait_core(input logic lvl, input int lim);
      wn = 0;
      while (core_in_reset !== lvl && wn < lim) begin @(posedge pclk); wn++; end
   endtask
   task automatic finish_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   // hang guard, well past the run
   initial begin
      repeat (6000) @(posedge pclk);
      miscompares++;
      finish_test;
   end
   // main sequence
   initial begin
      presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h0;
      pwdata = 32'h0; por_request = 1'h0; cpu_sleeping = 1'h0; pin_cmd = 1'h0;
      scan_cmd = 1'h0; key_cmd = 4'hF;
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      repeat (4) @(posedge pclk);
      check("reset_state", {battery_backup_indicator, port_input_mode, pull_down_cd,
         debounce_from_stage_ten, pump_duty, clear_duty, freq_gen_active, buzzer_level,
         converter_active, sense_resistor_outputs, timers_active, use_slow_crystal_clock,
         segments_forced, segment_force_level, clear_flags, core_in_reset, watchdog_armed_flag},
         {1'h1, 4'hF, 2'h3, 1'h1, `MRW_DUTY_QUARTER, `MRW_DUTY_QUARTER, 1'h0, 1'h0, 1'h0,
         3'h0, 2'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0});
      wait_core(1'h0, 200);
      check("init_cycle", wn >= CYC - 8 && wn <= CYC, 1);
      apb(1'h1, 12'h010, 32'h1);
      check("unmapped_write_err", rerr, 1);
      for (int i = 0; i < 5; i++) begin
         apb(1'h0, t_addr[i], 32'h0);
         check("reg_read", rdat & t_mask[i], t_exp[i]);
         check("reg_err", rerr, t_err[i]);
      end
      // arm, let it count, then pause it in sleep
      apb(1'h1, `MRW_CTRL_OFS, 32'h1);
      apb(1'h0, `MRW_STAT_OFS, 32'h0);
      check("armed_flag", rdat & 32'h2, 32'h2);
      apb(1'h0, `MRW_WDCNT_OFS, 32'h0);
      check("count_cleared", rdat <= 32'h1, 1);
      repeat (24) @(posedge pclk);
      apb(1'h0, `MRW_WDCNT_OFS, 32'h0);
      check("count_runs", rdat >= 32'h2, 1);
      apb(1'h1, `MRW_CTRL_OFS, 32'h1);
      cpu_sleeping <= 1'h1;
      apb(1'h0, `MRW_WDCNT_OFS, 32'h0);
      c = rdat;
      repeat (40) @(posedge pclk);
      apb(1'h0, `MRW_WDCNT_OFS, 32'h0);
      check("count_frozen", rdat, c);
      cpu_sleeping <= 1'h0;
      repeat (24) @(posedge pclk);
      apb(1'h0, `MRW_WDCNT_OFS, 32'h0);
      check("count_resumed", rdat > c, 1);
      // overflow with no further clears
      apb(1'h1, `MRW_CTRL_OFS, 32'h1);
      wait_core(1'h1, 300);
      check("overflow_time", wn >= WD_T - 2 * SD && wn <= WD_T + 2 * SD + 8, 1);
      wait_core(1'h0, 200);
      apb(1'h0, `MRW_STAT_OFS, 32'h0);
      check("after_overflow", rdat & 32'hF2, {`MRW_CAUSE_WDOG, 4'h2});
      // long pin high: level twin holds, pulse twin lets go
      pin_cmd <= 1'h1;
      repeat (100) @(posedge pclk);
      check("level_hold", core_in_reset, 1);
      check("pulse_release", pulse_in_reset, 0);
      pin_cmd <= 1'h0;
      wait_core(1'h0, 200);
      check("after_pin_cycle", wn >= CYC && wn <= CYC + 8, 1);
      apb(1'h0, `MRW_STAT_OFS, 32'h0);
      check("after_pin_stat", rdat & 32'hF2, {`MRW_CAUSE_PIN, 4'h0});
      // port keys: partial press with all enabled, then one enabled key
      key_cmd <= 4'hE;
      repeat (20) @(posedge pclk);
      check("partial_keys", core_in_reset, 0);
      apb(1'h1, `MRW_CFG_OFS, 32'h1);
      wait_core(1'h1, 20);
      check("key_reset", core_in_reset, 1);
      key_cmd <= 4'hF;
      wait_core(1'h0, 200);
      // matrix keys wait for the scan pulse
      apb(1'h1, `MRW_CFG_OFS, 32'h11);
      key_cmd <= 4'hE;
      repeat (30) @(posedge pclk);
      check("matrix_waits", core_in_reset, 0);
      scan_cmd <= 1'h1;
      wait_core(1'h1, 20);
      check("matrix_reset", core_in_reset, 1);
      scan_cmd <= 1'h0;
      key_cmd <= 4'hF;
      wait_core(1'h0, 200);
      finish_test;
   end
endmodule
